/* hdl/isoirq_pkg.sv */
package isoirq_pkg;
    // byte offsets on the register bus
    localparam logic [7:0] ISOIRQ_TX_MASK_SET_OFS = 8'h98;
    localparam logic [7:0] ISOIRQ_TX_MASK_CLR_OFS = 8'h9c;
    localparam logic [7:0] ISOIRQ_RX_EVENT_SET_OFS = 8'ha0;
    localparam logic [7:0] ISOIRQ_RX_EVENT_CLR_OFS = 8'ha4;
    localparam logic [7:0] ISOIRQ_RX_MASK_SET_OFS = 8'ha8;
    localparam logic [7:0] ISOIRQ_RX_MASK_CLR_OFS = 8'hac;
    localparam logic [7:0] ISOIRQ_INIT_BW_OFS = 8'hb0;
    localparam logic [7:0] ISOIRQ_TX_EVENT_OFS = 8'hc0;
    localparam logic [7:0] ISOIRQ_CTRL_OFS = 8'hc4;
    // field widths and reset values
    localparam int ISOIRQ_TX_CTX = 8;
    localparam int ISOIRQ_RX_CTX = 4;
    localparam int ISOIRQ_BW_W = 13;
    localparam logic [7:0] ISOIRQ_TX_MASK_RST = 8'h00;
    localparam logic [3:0] ISOIRQ_RX_MASK_RST = 4'h0;
    localparam logic [3:0] ISOIRQ_RX_EVENT_RST = 4'h0;
    localparam logic [7:0] ISOIRQ_TX_EVENT_RST = 8'h00;
    localparam logic [12:0] ISOIRQ_BW_RST = 13'h1333;
    // control register bit positions
    localparam int ISOIRQ_CTRL_SOFT_RST_BIT = 0;
    localparam int ISOIRQ_CTRL_TX_SUM_MASK_BIT = 1;
    localparam int ISOIRQ_CTRL_RX_SUM_MASK_BIT = 2;
    // htrans codes
    localparam logic [1:0] ISOIRQ_HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] ISOIRQ_HTRANS_SEQ = 2'b11;
endpackage

/* hdl/isoirq_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - tx mask bits set via 98h, cleared via 9Ch, gate tx contexts to summary
// - reads at either tx mask address return the tx mask
// - tx mask bit position matches its tx event bit
// - rx event raised when a context's input descriptor completes with irq
// - rx event set on rising edge of context irq or set-address write of 1
// - rx event cleared only by writing 1 at the clear address, or by hardware reset or soft reset
// - rx event bits 3..0 name the context behind summary receive event
// - rx event bits 31..4 read as zero
// - rx mask set/clear addresses, resets to all zeros
// - rx mask reads at both addresses; bit aligns with event bit
// - bandwidth field resets to 1333h, survives 1394 bus reset
// - bandwidth field copied to bandwidth CSR on each external reset source and on soft reset
// - bandwidth bits 31..13 read zero, writes ignored
// - tx event bits 7..0 name the context behind summary transmit event
// - summary receive irq only when summary mask and summary event both 1
module isoirq_regs
    import isoirq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // context interrupt lines, level from the dma engines
    input wire logic [ISOIRQ_TX_CTX-1:0] tx_ctx_irq,
    input wire logic [ISOIRQ_RX_CTX-1:0] rx_ctx_irq,
    // reset sources
    input wire logic global_reset_input,
    input wire logic pcie_fund_reset,
    input wire logic phy_side_reset_input,
    input wire logic bus_reset,
    // bus-management csr load
    output logic [ISOIRQ_BW_W-1:0] bw_csr_value,
    output logic bw_csr_load,
    // summary events and interrupt
    output logic iso_transmit_summary_event,
    output logic iso_receive_summary_event,
    output logic irq
);

    logic [ISOIRQ_TX_CTX-1:0] tx_mask_reg;
    logic [ISOIRQ_TX_CTX-1:0] tx_event_reg;
    logic [ISOIRQ_RX_CTX-1:0] rx_mask_reg;
    logic [ISOIRQ_RX_CTX-1:0] rx_event_reg;
    logic [ISOIRQ_TX_CTX-1:0] tx_irq_d_reg;
    logic [ISOIRQ_RX_CTX-1:0] rx_irq_d_reg;
    logic [ISOIRQ_BW_W-1:0] bw_reg;
    logic tx_sum_mask_reg;
    logic rx_sum_mask_reg;
    logic soft_rst_reg;
    // soft reset delayed past the field's own reinit
    logic soft_load_reg;
    logic [7:0] dp_addr_reg;
    logic dp_write_reg;
    logic dp_read_reg;
    logic [31:0] rdata_next;
    logic addr_ok;
    logic take;
    logic [7:0] waddr;
    logic wr_en;
    logic init_rst;

    function automatic logic is_wr(input logic [7:0] a,
                                   input logic [7:0] ofs,
                                   input logic en);
        is_wr = en && (a == ofs);
    endfunction

    // single-cycle slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
    assign take = hsel && hready
        && (htrans == ISOIRQ_HTRANS_NONSEQ || htrans == ISOIRQ_HTRANS_SEQ);

    always_ff @(posedge mclk) begin
        if (rst) begin
            dp_addr_reg <= 8'h00;
            dp_write_reg <= 1'b0;
            dp_read_reg <= 1'b0;
        end else begin
            dp_addr_reg <= haddr[7:0];
            dp_write_reg <= take && hwrite && addr_ok;
            dp_read_reg <= take && !hwrite;
        end
    end

    assign waddr = dp_addr_reg;
    assign wr_en = dp_write_reg;
    // hardware or software reset restores the initial values
    assign init_rst = rst || soft_rst_reg;

    // edge detect context lines
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_irq_d_reg <= '0;
            rx_irq_d_reg <= '0;
        end else begin
            tx_irq_d_reg <= tx_ctx_irq;
            rx_irq_d_reg <= rx_ctx_irq;
        end
    end

    // tx mask
    always_ff @(posedge mclk) begin
        if (init_rst) begin
            tx_mask_reg <= ISOIRQ_TX_MASK_RST;
        end else if (is_wr(waddr, ISOIRQ_TX_MASK_SET_OFS, wr_en)) begin
            tx_mask_reg <= tx_mask_reg | hwdata[ISOIRQ_TX_CTX-1:0];
        end else if (is_wr(waddr, ISOIRQ_TX_MASK_CLR_OFS, wr_en)) begin
            tx_mask_reg <= tx_mask_reg & ~hwdata[ISOIRQ_TX_CTX-1:0];
        end
    end

    // tx event: edge sets, set wins over clear
    always_ff @(posedge mclk) begin
        if (init_rst) begin
            tx_event_reg <= ISOIRQ_TX_EVENT_RST;
        end else if (is_wr(waddr, ISOIRQ_TX_EVENT_OFS, wr_en)) begin
            tx_event_reg <= (tx_event_reg & ~hwdata[ISOIRQ_TX_CTX-1:0])
                | (tx_ctx_irq & ~tx_irq_d_reg);
        end else begin
            tx_event_reg <= tx_event_reg | (tx_ctx_irq & ~tx_irq_d_reg);
        end
    end

    // rx event
    always_ff @(posedge mclk) begin
        if (init_rst) begin
            rx_event_reg <= ISOIRQ_RX_EVENT_RST;
        end else if (is_wr(waddr, ISOIRQ_RX_EVENT_SET_OFS, wr_en)) begin
            rx_event_reg <= rx_event_reg | hwdata[ISOIRQ_RX_CTX-1:0]
                | (rx_ctx_irq & ~rx_irq_d_reg);
        end else if (is_wr(waddr, ISOIRQ_RX_EVENT_CLR_OFS, wr_en)) begin
            // a fresh edge in the clear cycle survives
            rx_event_reg <= (rx_event_reg & ~hwdata[ISOIRQ_RX_CTX-1:0])
                | (rx_ctx_irq & ~rx_irq_d_reg);
        end else begin
            rx_event_reg <= rx_event_reg | (rx_ctx_irq & ~rx_irq_d_reg);
        end
    end

    // rx mask
    always_ff @(posedge mclk) begin
        if (init_rst) begin
            rx_mask_reg <= ISOIRQ_RX_MASK_RST;
        end else if (is_wr(waddr, ISOIRQ_RX_MASK_SET_OFS, wr_en)) begin
            rx_mask_reg <= rx_mask_reg | hwdata[ISOIRQ_RX_CTX-1:0];
        end else if (is_wr(waddr, ISOIRQ_RX_MASK_CLR_OFS, wr_en)) begin
            rx_mask_reg <= rx_mask_reg & ~hwdata[ISOIRQ_RX_CTX-1:0];
        end
    end

    // bandwidth seed, untouched by bus reset
    always_ff @(posedge mclk) begin
        if (init_rst) begin
            bw_reg <= ISOIRQ_BW_RST;
        end else if (is_wr(waddr, ISOIRQ_INIT_BW_OFS, wr_en)) begin
            bw_reg <= hwdata[ISOIRQ_BW_W-1:0];
        end
    end

    // soft reset loads one cycle late so the csr gets the reset seed,
    // not the value that the reinit is just throwing away
    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_load_reg <= 1'b0;
        end else begin
            soft_load_reg <= soft_rst_reg;
        end
    end

    // load pulse one cycle after any external reset source, two cycles after a soft reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            bw_csr_load <= 1'b0;
            bw_csr_value <= ISOIRQ_BW_RST;
        end else begin
            bw_csr_load <= soft_load_reg || global_reset_input
                || pcie_fund_reset || phy_side_reset_input
                || bus_reset;
            bw_csr_value <= bw_reg;
        end
    end

    // control: soft reset self-clears, summary masks
    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_rst_reg <= 1'b0;
            tx_sum_mask_reg <= 1'b0;
            rx_sum_mask_reg <= 1'b0;
        end else if (is_wr(waddr, ISOIRQ_CTRL_OFS, wr_en)) begin
            soft_rst_reg <= hwdata[ISOIRQ_CTRL_SOFT_RST_BIT];
            tx_sum_mask_reg <= hwdata[ISOIRQ_CTRL_TX_SUM_MASK_BIT];
            rx_sum_mask_reg <= hwdata[ISOIRQ_CTRL_RX_SUM_MASK_BIT];
        end else begin
            soft_rst_reg <= 1'b0;
        end
    end

    // summary events: any enabled context event
    assign iso_transmit_summary_event = |(tx_event_reg & tx_mask_reg);
    assign iso_receive_summary_event = |(rx_event_reg & rx_mask_reg);
    // summary irq needs both mask and event
    assign irq = (iso_receive_summary_event && rx_sum_mask_reg)
        || (iso_transmit_summary_event && tx_sum_mask_reg);

    // read mux, registered at data phase start
    always_comb begin
        rdata_next = 32'h00000000;
        case (haddr[7:0])
            ISOIRQ_TX_MASK_SET_OFS, ISOIRQ_TX_MASK_CLR_OFS: begin
                rdata_next[ISOIRQ_TX_CTX-1:0] = tx_mask_reg;
            end
            ISOIRQ_RX_EVENT_SET_OFS: begin
                rdata_next[ISOIRQ_RX_CTX-1:0] = rx_event_reg;
            end
            ISOIRQ_RX_EVENT_CLR_OFS: begin
                rdata_next[ISOIRQ_RX_CTX-1:0] = rx_event_reg & rx_mask_reg;
            end
            ISOIRQ_RX_MASK_SET_OFS, ISOIRQ_RX_MASK_CLR_OFS: begin
                rdata_next[ISOIRQ_RX_CTX-1:0] = rx_mask_reg;
            end
            ISOIRQ_INIT_BW_OFS: begin
                rdata_next[ISOIRQ_BW_W-1:0] = bw_reg;
            end
            ISOIRQ_TX_EVENT_OFS: begin
                rdata_next[ISOIRQ_TX_CTX-1:0] = tx_event_reg;
            end
            ISOIRQ_CTRL_OFS: begin
                rdata_next[ISOIRQ_CTRL_TX_SUM_MASK_BIT] = tx_sum_mask_reg;
                rdata_next[ISOIRQ_CTRL_RX_SUM_MASK_BIT] = rx_sum_mask_reg;
            end
            default: begin
                rdata_next = 32'h00000000;
            end
        endcase
        if (!addr_ok) begin
            rdata_next = 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            hrdata <= 32'h00000000;
        end else if (take && !hwrite) begin
            hrdata <= rdata_next;
        end
    end

endmodule
`default_nettype wire

/* verif/isoirq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module isoirq_sva
    import isoirq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // reset sources and csr copy
    input wire logic global_reset_input,
    input wire logic pcie_fund_reset,
    input wire logic phy_side_reset_input,
    input wire logic bus_reset,
    input wire logic [ISOIRQ_BW_W-1:0] bw_csr_value,
    input wire logic bw_csr_load,
    // summaries
    input wire logic iso_transmit_summary_event,
    input wire logic iso_receive_summary_event,
    input wire logic irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] o);
        hsel && hready && htrans[1] && !hwrite && haddr == {24'h0, o};
    endsequence
    // read data lands one cycle after the address phase
    property p_zero(logic [7:0] o, logic [31:0] m);
        s_rd(o) |=> (hrdata & m) == 32'h0;
    endproperty
    a_rx_rsvd_zero: assert property (p_zero(8'ha0, 32'hffff_fff0))
        else $error("rx event reserved bits set");
    a_rx_mask_rsvd: assert property (p_zero(8'ha8, 32'hffff_fff0))
        else $error("rx mask reserved bits set");
    a_tx_mask_rsvd: assert property (p_zero(8'h9c, 32'hffff_ff00))
        else $error("tx mask reserved bits set");
    a_bw_rsvd_zero: assert property (p_zero(8'hb0, 32'hffff_e000))
        else $error("bandwidth reserved bits set");
    a_unmapped_zero: assert property (p_zero(8'hb4, 32'hffff_ffff))
        else $error("unmapped read not zero");
    a_load_follows: assert property ((global_reset_input | pcie_fund_reset
        | phy_side_reset_input | bus_reset) |=> bw_csr_load)
        else $error("bandwidth copy missing");
    a_irq_needs_sum: assert property (irq |->
        (iso_receive_summary_event || iso_transmit_summary_event))
        else $error("irq without summary");
    a_reset_state: assert property ($fell(rst) |-> bw_csr_value == 13'h1333
        && !irq && !iso_receive_summary_event)
        else $error("bad state after reset");
endmodule
bind isoirq_regs isoirq_sva u_sva (.mclk(mclk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .global_reset_input(global_reset_input),
    .pcie_fund_reset(pcie_fund_reset), .bus_reset(bus_reset),
    .phy_side_reset_input(phy_side_reset_input), .irq(irq),
    .bw_csr_value(bw_csr_value), .bw_csr_load(bw_csr_load),
    .iso_transmit_summary_event(iso_transmit_summary_event),
    .iso_receive_summary_event(iso_receive_summary_event));
`default_nettype wire

/* verif/tb_isoirq_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_isoirq_regs;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] tx = 8'h00;
    logic [3:0] rx = 4'h0;
    logic [3:0] rsrc = 4'h0;
    logic hready, hresp, load, tx_sum, rx_sum, irq;
    logic [31:0] hrdata;
    logic [12:0] bw;
    int n_fail = 0;
    int n_checks = 0;
    always #5 mclk = ~mclk;
    isoirq_regs dut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .tx_ctx_irq(tx), .rx_ctx_irq(rx),
        .global_reset_input(rsrc[0]), .pcie_fund_reset(rsrc[1]),
        .phy_side_reset_input(rsrc[2]), .bus_reset(rsrc[3]),
        .bw_csr_value(bw), .bw_csr_load(load),
        .iso_transmit_summary_event(tx_sum),
        .iso_receive_summary_event(rx_sum), .irq(irq));
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    // single transfer; hready is sampled, never assumed
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge mclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge mclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rc(input string nm, input logic [7:0] a,
            input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask
    task t_rx;
        rc("rx_mask", 8'ha8, 32'h0);
        wr(8'ha8, 32'h0000_000f);
        wr(8'hc4, 32'h0000_0004);
        rx <= 4'h4;
        repeat (2) @(posedge mclk);
        rc("rx_event", 8'ha0, 32'h4);
        chk("rx_sum", 1, rx_sum);
        chk("irq", 1, irq);
        wr(8'ha4, 32'h0);
        wr(8'ha0, 32'hffff_fff1);
        rc("rx_event", 8'ha0, 32'h5);
        wr(8'hac, 32'h4);
        rc("rx_mask", 8'hac, 32'hb);
        rc("rx_and", 8'ha4, 32'h1);
        wr(8'ha4, 32'h5);
        #1 chk("irq", 0, irq);
        rc("rx_event", 8'ha0, 32'h0);
        rx <= 4'h0;
        $display("test rx done");
    endtask
    task t_tx;
        wr(8'h98, 32'hffff_ffff);
        rc("tx_mask", 8'h9c, 32'h0000_00ff);
        wr(8'h9c, 32'h0000_000f);
        rc("tx_mask", 8'h98, 32'h0000_00f0);
        wr(8'hc4, 32'h0000_0002);
        tx <= 8'h01;
        repeat (3) @(posedge mclk);
        #1 chk("tx_sum", 0, tx_sum);
        tx <= 8'h81;
        repeat (3) @(posedge mclk);
        #1 chk("tx_sum", 1, tx_sum);
        chk("irq", 1, irq);
        $display("test tx done");
    endtask
    task t_bw;
        rc("bw", 8'hb0, 32'h0000_1333);
        wr(8'hb0, 32'hffff_ffff);
        rc("bw", 8'hb0, 32'h0000_1fff);
        rc("unmapped", 8'hb4, 32'h0);
        // bus reset first: the others may reload the field
        for (int i = 3; i >= 0; i--) begin
            rsrc <= 4'h1 << i;
            @(posedge mclk);
            rsrc <= 4'h0;
            #1 chk("bw_load", 1, load);
            if (i == 3) chk("bw_csr", 32'h1fff, bw);
            @(posedge mclk);
        end
        $display("test bw done");
    endtask
    // tx event clear, then soft reset reinit and csr reload
    task t_soft;
        rc("tx_event", 8'hc0, 32'h81);
        wr(8'hc0, 32'h1);
        rc("tx_event", 8'hc0, 32'h80);
        wr(8'hc4, 32'h1);
        repeat (2) @(posedge mclk);
        #1 chk("bw_load", 1, load);
        chk("bw_csr", 32'h1333, bw);
        rc("bw", 8'hb0, 32'h0000_1333);
        rc("rx_mask", 8'hac, 32'h0);
        rc("tx_mask", 8'h98, 32'h0);
        rc("tx_event", 8'hc0, 32'h0);
        $display("test soft done");
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_rx;
        t_tx;
        t_bw;
        t_soft;
        end_of_test;
    end
    initial begin
        #100000;
        n_fail++;
        end_of_test;
    end
endmodule
`default_nettype wire
